// file: rtl/msc_conv.sv
// Purpose: channel latch, decode and 8-step SAR sequencer of a 16-input converter
// Assumes: all pin inputs asynchronous to clk; comparator high means input at or above ladder tap
// Notes: the analog ladder and comparator sit outside; this block drives the tap code
`timescale 1ns/10ps
`include "msc_params.svh"

module msc_conv #(
  parameter int unsigned TICK_CYC = `MSC_CONV_TICK_CYC,
  parameter int unsigned TICKS_PER_BIT = `MSC_TICKS_PER_BIT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ale,
  input wire msc_pkg::msc_chan_s chan_pins,
  input wire logic conv_trigger,
  input wire logic cmp_above,
  input wire logic out_en,
  output logic [`MSC_CHANNELS-1:0] mux_sel,
  output logic [`MSC_SAR_BITS-1:0] ladder_code,
  output logic eoc,
  output logic [`MSC_SAR_BITS-1:0] data_out,
  output logic data_oe
);

  // ==========================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // pin synchronisers
  msc_pkg::msc_pins_s pins_raw;
  msc_pkg::msc_pins_s pins_meta_q;
  msc_pkg::msc_pins_s pins_q;
  logic ale_d1_q;
  logic trig_d1_q;
  logic ale_rise;
  logic trig_rise;
  logic trig_fall;

  assign pins_raw = '{ale: ale, trig: conv_trigger, cmp: cmp_above, oe: out_en, chan: chan_pins};

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pins_meta_q <= '0;
      pins_q <= '0;
      ale_d1_q <= 1'b0;
      trig_d1_q <= 1'b0;
    end else begin
      pins_meta_q <= pins_raw;
      pins_q <= pins_meta_q;
      ale_d1_q <= pins_q.ale;
      trig_d1_q <= pins_q.trig;
    end
  end

  assign ale_rise = pins_q.ale && !ale_d1_q;
  // a trigger shorter than the sync window may be missed, hence the width demand
  assign trig_rise = pins_q.trig && !trig_d1_q;
  assign trig_fall = !pins_q.trig && trig_d1_q;

  // ==========================================================
  // channel latch and decode
  logic [3:0] addr_q;
  logic [`MSC_CHANNELS-1:0] mux_sel_q;

  // free of the sequencer, so a channel may change mid-conversion
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      addr_q <= `MSC_ADDR_RESET;
    end else if (ale_rise) begin
      addr_q <= pins_q.chan.addr;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mux_sel_q <= `MSC_MUX_OFF;
    end else if (pins_q.chan.exp_en) begin
      mux_sel_q <= `MSC_MUX_ONE << addr_q;
    end else begin
      mux_sel_q <= `MSC_MUX_OFF;
    end
  end

  assign mux_sel = mux_sel_q;

  // ==========================================================
  // converter clock tick and bit timer
  logic [15:0] tick_cnt_q;
  logic [7:0] step_cnt_q;
  logic [`MSC_SAR_BITS-1:0] trial_q;
  logic tick;
  logic bit_end;
  msc_pkg::msc_state_e state_q;

  assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tick_cnt_q <= 16'h0000;
    end else if (tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign bit_end = (state_q == msc_pkg::ST_RUN) && tick && (step_cnt_q == 8'(TICKS_PER_BIT - 1));

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      step_cnt_q <= 8'h00;
    end else if (state_q != msc_pkg::ST_RUN || bit_end) begin
      step_cnt_q <= 8'h00;
    end else if (tick) begin
      step_cnt_q <= step_cnt_q + 8'h01;
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= msc_pkg::ST_IDLE;
    end else if (trig_rise) begin
      state_q <= msc_pkg::ST_HOLD;
    end else begin
      case (state_q)
        msc_pkg::ST_HOLD: begin
          if (trig_fall) begin
            state_q <= msc_pkg::ST_RUN;
          end
        end
        msc_pkg::ST_RUN: begin
          if (bit_end && trial_q[0]) begin
            state_q <= msc_pkg::ST_LATCH;
          end
        end
        msc_pkg::ST_LATCH: begin
          if (tick) begin
            state_q <= msc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // ==========================================================
  // approximation register
  logic [`MSC_SAR_BITS-1:0] sar_q;
  logic [`MSC_SAR_BITS-1:0] sar_d;
  logic [`MSC_SAR_BITS-1:0] trial_d;
  logic [`MSC_SAR_BITS-1:0] ladder_q;
  logic [`MSC_SAR_BITS-1:0] result_q;
  logic [3:0] bits_done_q;

  always_comb begin
    sar_d = sar_q;
    trial_d = trial_q;
    if (trig_rise) begin
      sar_d = `MSC_SAR_RESET;
      trial_d = `MSC_TRIAL_MSB;
    end else if (bit_end) begin
      // keep the bit when the input sits at or above the tap; taps equal the code, with no half-LSB offset
      if (pins_q.cmp) begin
        sar_d = sar_q | trial_q;
      end
      trial_d = trial_q >> 1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sar_q <= `MSC_SAR_RESET;
      trial_q <= `MSC_SAR_RESET;
      ladder_q <= `MSC_SAR_RESET;
    end else begin
      sar_q <= sar_d;
      trial_q <= trial_d;
      ladder_q <= sar_d | trial_d;
    end
  end

  assign ladder_code = ladder_q;

  // result held from one completion to the next
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      result_q <= `MSC_SAR_RESET;
    end else if (bit_end && trial_q[0] && !trig_rise) begin
      result_q <= sar_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bits_done_q <= 4'h0;
    end else if (trig_rise) begin
      bits_done_q <= 4'h0;
    end else if (bit_end) begin
      bits_done_q <= bits_done_q + 4'h1;
    end
  end

  // ==========================================================
  // done flag
  logic eoc_q;

  // low after reset so a looped-back trigger needs one outside pulse to start
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      eoc_q <= 1'b0;
    end else if (trig_rise) begin
      eoc_q <= 1'b0;
    end else if (state_q == msc_pkg::ST_LATCH && tick) begin
      eoc_q <= 1'b1;
    end
  end

  assign eoc = eoc_q;

  // ==========================================================
  // result outputs
  logic [`MSC_SAR_BITS-1:0] data_out_q;
  logic data_oe_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_out_q <= `MSC_SAR_RESET;
      data_oe_q <= 1'b0;
    end else begin
      data_out_q <= result_q;
      data_oe_q <= pins_q.oe;
    end
  end

  assign data_out = data_out_q;
  assign data_oe = data_oe_q;

  // ==========================================================
  // checks
  AST_ADDR_LATCH:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      ale_rise |=> addr_q == $past(pins_q.chan.addr) ##1 addr_q == $past(addr_q) || $past(ale_rise))
    else $error("address not captured on strobe edge");

  AST_MUX_ONE_HOT:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      pins_q.chan.exp_en |=> $onehot(mux_sel) && mux_sel[$past(addr_q)])
    else $error("selected channel does not match address");

  AST_MUX_OFF:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      !pins_q.chan.exp_en |=> mux_sel == `MSC_MUX_OFF)
    else $error("multiplexer not off with expansion low");

  AST_EIGHT_BITS:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      $rose(eoc_q) |-> bits_done_q == 4'h8)
    else $error("conversion did not make eight decisions");

  AST_SAR_CLEAR:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      trig_rise |=> sar_q == `MSC_SAR_RESET && ladder_code == `MSC_TRIAL_MSB)
    else $error("register not cleared on trigger rise");

  AST_WAIT_FALL:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      state_q == msc_pkg::ST_HOLD && pins_q.trig |=> state_q == msc_pkg::ST_HOLD)
    else $error("sequence began before trigger fell");

  AST_RESTART:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      state_q == msc_pkg::ST_RUN && trig_rise |=> state_q == msc_pkg::ST_HOLD && bits_done_q == 4'h0)
    else $error("running conversion not abandoned");

  AST_EOC_LOW:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      trig_rise |=> !eoc_q [*2])
    else $error("done not low after trigger rise");

  AST_RESULT_FIRST:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      $rose(eoc_q) |-> $past(state_q) == msc_pkg::ST_LATCH && result_q == sar_q)
    else $error("result not latched before done rose");

  AST_RESULT_HOLD:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      $changed(result_q) |-> $past(state_q) == msc_pkg::ST_RUN && state_q == msc_pkg::ST_LATCH)
    else $error("result changed outside completion");

  AST_OE_GATE:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      !pins_q.oe |=> !data_oe)
    else $error("outputs driven without enable");

endmodule : msc_conv

// file: rtl/msc_params.svh
// Purpose: constants of the multiplexed SAR conversion control
// Assumes: 125 MHz system clock
// Notes: the tick count derives from the two clock rates by expression; ticks per bit and widths are literals
`ifndef MSC_PARAMS_SVH
`define MSC_PARAMS_SVH

// ==========================================================
// clock and timing
`define MSC_CLK_KHZ 125000
`define MSC_CONV_CLK_KHZ 640
`define MSC_CONV_TICK_CYC (`MSC_CLK_KHZ / `MSC_CONV_CLK_KHZ)
`define MSC_TICKS_PER_BIT 8

// ==========================================================
// widths and reset values
`define MSC_SAR_BITS 8
`define MSC_CHANNELS 16
`define MSC_SAR_RESET 8'h00
`define MSC_TRIAL_MSB 8'h80
`define MSC_ADDR_RESET 4'h0
`define MSC_MUX_OFF 16'h0000
`define MSC_MUX_ONE 16'h0001

`endif

// file: rtl/msc_pkg.sv
// Purpose: types of the multiplexed SAR conversion control
// Assumes: nothing
// Notes: constants live in msc_params.svh
package msc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOLD,
    ST_RUN,
    ST_LATCH
  } msc_state_e;

  typedef struct packed {
    logic exp_en;
    logic [3:0] addr;
  } msc_chan_s;

  typedef struct packed {
    logic ale;
    logic trig;
    logic cmp;
    logic oe;
    msc_chan_s chan;
  } msc_pins_s;

endpackage : msc_pkg

// file: sim/msc_analog_model.sv
// Purpose: analog side of the converter, inputs, switch tree and comparator
// Assumes: channel i carries level i*17; the ladder tap equals the code
// Notes: with no switch closed the comparator sees the external level
`timescale 1ns/10ps

module msc_analog_model (
  input wire logic [15:0] mux_sel,
  input wire logic [7:0] ladder_code,
  input wire logic [7:0] ext_level,
  output logic cmp_above
);
  logic [7:0] level;

  // ==========================================================
  // switch tree and comparator
  always_comb begin
    level = ext_level;
    for (int i = 0; i < 16; i++) begin
      if (mux_sel[i]) begin
        level = 8'(i * 17);
      end
    end
    cmp_above = (level >= ladder_code);
  end
endmodule : msc_analog_model

// file: sim/tb_top.sv
// Purpose: self-checking bench of the conversion control
// Assumes: shortened ticks, TICK_CYC 4 and one tick a bit
// Notes: a tick must outlast the comparator sync delay; a conversion takes about 40 clocks
`timescale 1ns/10ps

module tb_top;
  logic clk, rstn, ale, trig_drv, free_run, out_en, cmp_above, eoc, data_oe, conv_trigger;
  msc_pkg::msc_chan_s chan;
  logic [7:0] ext_level, ladder_code, data_out;
  logic [15:0] mux_sel;
  int errors, n_compared, cyc;

  // done looped back to the trigger in continuous mode
  assign conv_trigger = free_run ? (eoc | trig_drv) : trig_drv;

  msc_conv #(.TICK_CYC(4), .TICKS_PER_BIT(1)) dut (.clk(clk), .rstn(rstn), .ale(ale), .chan_pins(chan),
    .conv_trigger(conv_trigger), .cmp_above(cmp_above), .out_en(out_en), .mux_sel(mux_sel),
    .ladder_code(ladder_code), .eoc(eoc), .data_out(data_out), .data_oe(data_oe));
  msc_analog_model model (.mux_sel(mux_sel), .ladder_code(ladder_code), .ext_level(ext_level),
    .cmp_above(cmp_above));

  // ==========================================================
  // clock, watchdog and shared tasks
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("ERROR %0t watchdog expired", $time);
      end_of_test();
    end
  end

  task end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task cyc_n(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc_n

  task latch(input logic [3:0] a, input logic en);
    chan = '{exp_en: en, addr: a};
    ale = 1'b1;
    cyc_n(3);
    ale = 1'b0;
    cyc_n(3);
  endtask : latch

  // a long high phase would let a wrong start edge finish early
  task pulse(input int hi);
    trig_drv = 1'b1;
    cyc_n(hi);
    chk(eoc, 1'b0, "done low while trigger high");
    trig_drv = 1'b0;
  endtask : pulse

  task wait_eoc;
    int n;
    n = 0;
    while (eoc !== 1'b1 && n < 400) begin
      cyc_n(1);
      n++;
    end
    chk(16'(n < 400), 16'h1, "done seen");
  endtask : wait_eoc

  task conv(input logic [3:0] a, input logic en, input logic [7:0] exp);
    latch(a, en);
    pulse(20);
    wait_eoc();
    chk(data_out, exp, "result at done");
  endtask : conv

  // ==========================================================
  // scenarios
  task t_chan;
    for (int i = 0; i < 16; i++) begin
      latch(4'(i), 1'b1);
      chk(mux_sel, 16'h0001 << i, "select");
    end
    chan.addr = 4'h5;
    cyc_n(6);
    chk(mux_sel, 16'h8000, "address held");
    chan.exp_en = 1'b0;
    cyc_n(6);
    chk(mux_sel, 16'h0000, "all off");
    $display("test chan done");
  endtask : t_chan

  task t_conv;
    out_en = 1'b1;
    conv(4'h0, 1'b1, 8'h00);
    conv(4'h7, 1'b1, 8'h77);
    conv(4'hf, 1'b1, 8'hff);
    conv(4'h3, 1'b0, 8'h5a);
    chk(data_oe, 1'b1, "drive on");
    out_en = 1'b0;
    cyc_n(4);
    chk(data_oe, 1'b0, "drive off");
    out_en = 1'b1;
    latch(4'h2, 1'b1);
    pulse(60);
    wait_eoc();
    chk(data_out, 8'h22, "result after long trigger");
    $display("test conv done");
  endtask : t_conv

  task t_abort;
    latch(4'hf, 1'b1);
    pulse(20);
    chk(data_out, 8'h22, "old result held");
    cyc_n(8);
    latch(4'h0, 1'b1);
    pulse(20);
    wait_eoc();
    chk(data_out, 8'h00, "restarted result");
    $display("test abort done");
  endtask : t_abort

  task t_free;
    int rises;
    logic prev;
    rises = 0;
    latch(4'h9, 1'b1);
    free_run = 1'b1;
    pulse(20);
    prev = eoc;
    repeat (200) begin
      cyc_n(1);
      if (eoc === 1'b1 && prev !== 1'b1) rises++;
      prev = eoc;
    end
    chk(16'(rises >= 3), 16'h1, "continuous runs");
    chk(data_out, 8'h99, "continuous result");
    free_run = 1'b0;
    $display("test free done");
  endtask : t_free

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'b0;
    ale = 1'b0;
    trig_drv = 1'b0;
    free_run = 1'b0;
    out_en = 1'b0;
    chan = '{exp_en: 1'b0, addr: 4'h0};
    ext_level = 8'h5a;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    cyc_n(4);
    rstn = 1'b1;
    cyc_n(4);
    t_chan();
    t_conv();
    t_abort();
    t_free();
    end_of_test();
  end
endmodule : tb_top
